// *** inc/uart_irq_defines.svh ***
// Offsets, field positions, reset values and identification codes of the
// interrupt enable and identification registers.
// Assumes a 3-bit channel register address and 8-bit data.
`ifndef UART_IRQ_DEFINES_SVH
`define UART_IRQ_DEFINES_SVH

// ==========================================================================
// Register offsets
`define IRQ_MASK_ADDR      3'h1
`define IRQ_REPORT_ADDR    3'h2

// ==========================================================================
// Mask register fields
`define MASK_RESET         8'h00
`define MASK_RX_DATA_BIT   0
`define MASK_TX_BIT        1
`define MASK_LINE_BIT      2
`define MASK_MODEM_BIT     3
`define MASK_SLEEP_BIT     4
`define MASK_PAUSE_BIT     5
`define MASK_RTS_BIT       6
`define MASK_CTS_BIT       7
`define MASK_LOW_NIBBLE    8'h0F
`define MASK_HIGH_NIBBLE   8'hF0

// ==========================================================================
// Report register fields and source codes
`define RPT_IDLE           8'h01
`define RPT_FLOW_BIT       5
`define RPT_PAUSE_BIT      4
`define CODE_LINE          3'h3
`define CODE_TIMEOUT       3'h6
`define CODE_RX_DATA       3'h2
`define CODE_TX            3'h1
`define CODE_MODEM         3'h0
`define READ_UNMAPPED      8'h00

`endif

// *** inc/uart_irq_pkg.sv ***
// Types shared by the interrupt enable and identification logic.
// Assumes the channel's source detectors deliver the struct below.
package uart_irq_pkg;

	// ======================================================================
	// Source inputs: levels first, then one-cycle event pulses
	typedef struct packed {
		logic line_error;
		logic rx_timeout;
		logic rx_data_ready;
		logic tx_below_level;
		logic modem_change;
		logic pause_char_rx;
		logic special_char_match;
		logic cts_to_inactive;
		logic rts_to_inactive;
	} irq_src_in_s;

	// ======================================================================
	// Source chosen for reporting, highest priority first
	typedef enum logic [2:0] {
		SRC_NONE    = 3'b000,
		SRC_LINE    = 3'b001,
		SRC_TIMEOUT = 3'b010,
		SRC_RX_DATA = 3'b011,
		SRC_TX      = 3'b100,
		SRC_MODEM   = 3'b101,
		SRC_PAUSE   = 3'b110,
		SRC_FLOW    = 3'b111
	} irq_src_e;

endpackage : uart_irq_pkg

// *** design/irq_event_latch.sv ***
// Sticky flag for one interrupt event.
// Assumes set and clear are synchronous to clk_sys.
`timescale 1ns/10ps
`default_nettype none

module irq_event_latch
(
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic set,
	input  wire logic clr,
	output logic      flag_q
);

	logic flag_d;

	// ======================================================================
	// Next value
	// An event that lands in the clearing cycle must not be lost.
	always_comb
	begin
		flag_d = flag_q;
		if (clr)
			flag_d = 1'b0;
		if (set)
			flag_d = 1'b1;
	end

	// ======================================================================
	// State
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			flag_q <= 1'b0;
		else
			flag_q <= flag_d;
	end

endmodule : irq_event_latch

`default_nettype wire

// *** design/irq_priority_encoder.sv ***
// Priority selection of the pending interrupt and its report byte.
// Assumes every source input is already gated by its enable bit.
`timescale 1ns/10ps
`default_nettype none

`include "uart_irq_defines.svh"

module irq_priority_encoder
(
	input  wire logic               line_error,
	input  wire logic               rx_timeout,
	input  wire logic               rx_data,
	input  wire logic               tx_space,
	input  wire logic               modem,
	input  wire logic               pause_char,
	input  wire logic               flow_change,
	input  wire logic               queue_enable,
	output uart_irq_pkg::irq_src_e  source,
	output logic [7:0]              report
);

	// ======================================================================
	// Selection
	always_comb
	begin
		source = uart_irq_pkg::SRC_NONE;
		if (line_error)
			source = uart_irq_pkg::SRC_LINE;
		else if (rx_timeout)
			source = uart_irq_pkg::SRC_TIMEOUT;
		else if (rx_data)
			source = uart_irq_pkg::SRC_RX_DATA;
		else if (tx_space)
			source = uart_irq_pkg::SRC_TX;
		else if (modem)
			source = uart_irq_pkg::SRC_MODEM;
		else if (pause_char)
			source = uart_irq_pkg::SRC_PAUSE;
		else if (flow_change)
			source = uart_irq_pkg::SRC_FLOW;
	end

	// ======================================================================
	// Report byte
	always_comb
	begin
		report = `RPT_IDLE;
		unique case (source)
			uart_irq_pkg::SRC_NONE:    report = `RPT_IDLE;
			uart_irq_pkg::SRC_LINE:    report[3:1] = `CODE_LINE;
			uart_irq_pkg::SRC_TIMEOUT: report[3:1] = `CODE_TIMEOUT;
			uart_irq_pkg::SRC_RX_DATA: report[3:1] = `CODE_RX_DATA;
			uart_irq_pkg::SRC_TX:      report[3:1] = `CODE_TX;
			uart_irq_pkg::SRC_MODEM:   report[3:1] = `CODE_MODEM;
			uart_irq_pkg::SRC_PAUSE:   report[`RPT_PAUSE_BIT] = 1'b1;
			uart_irq_pkg::SRC_FLOW:    report[`RPT_FLOW_BIT] = 1'b1;
		endcase
		if (source != uart_irq_pkg::SRC_NONE)
			report[0] = 1'b0;
		report[7] = queue_enable;
		report[6] = queue_enable;
	end

endmodule : irq_priority_encoder

`default_nettype wire

// *** design/uart_interrupt_enable_identify.sv ***
// Interrupt enable and identification logic of one UART channel.
// Assumes the register strobes are one-cycle pulses synchronous to clk_sys
// and that the source detectors, the queue, modem and feature registers
// live elsewhere and hand their bits in as levels or one-cycle pulses.
`timescale 1ns/10ps
`default_nettype none

`include "uart_irq_defines.svh"

// How it works
// - Mask bit 0 lets receive-data and time-out sources interrupt.
// - Mask bit 1 lets the transmit-space source interrupt.
// - Mask bit 2 lets receive line errors interrupt.
// - Mask bit 3 lets modem status changes interrupt.
// - Mask bit 4 puts the channel to sleep.
// - Mask bit 5 lets a received pause character interrupt.
// - Mask bit 7 gates CTS changes, bit 6 gates RTS changes.
// - Reset clears the whole mask: nothing interrupts, no sleep.
// - Mask bits 7..4 change only while the feature write enable is set.
// - Setting mask bit 1 again while below level raises a fresh interrupt.
// - The request pin rises whenever an enabled source is pending.
// - Report register is 8 bits, read only; writes to it are ignored.
// - Report bits 7 and 6 copy queue control bit 0.
// - Report bit 0 is 0 while something is pending, else 1.
// - Report bit 5 flags a CTS or RTS change to inactive.
// - Report bit 4 flags a pause or special character.
// - Bits 3..1 code line 011, time-out 110, data 010, tx 001, modem 000.
// - Pause character is priority 6, flow-line change priority 7.
// - Request pin floats unless the modem-control output enable is set.
// - A special character match, when enabled, sets report bit 4.
module uart_interrupt_enable_identify
(
	input  wire logic                    clk_sys,
	input  wire logic                    rst_n,
	input  wire logic [2:0]              reg_addr,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	input  wire logic [7:0]              reg_wdata,
	output logic [7:0]                   reg_rdata,
	input  wire logic                    efr_write_enable,
	input  wire logic                    efr_special_detect,
	input  wire logic                    fcr_queue_enable,
	input  wire logic                    mcr_irq_output_enable,
	input  wire uart_irq_pkg::irq_src_in_s src,
	input  wire logic                    thr_write,
	output logic                         service_request,
	output logic                         service_request_oe,
	output logic                         sleep_mode
);

	// ======================================================================
	// Decoding

	function automatic logic reg_hit(input logic [2:0] addr,
		input logic [2:0] target, input logic strobe);
		reg_hit = strobe && (addr == target);
	endfunction : reg_hit

	logic mask_wr;
	logic report_rd;
	logic mask_rd;

	assign mask_wr   = reg_hit(reg_addr, `IRQ_MASK_ADDR, reg_wr);
	assign mask_rd   = reg_hit(reg_addr, `IRQ_MASK_ADDR, reg_rd);
	// A write to the report offset matches nothing and is dropped.
	assign report_rd = reg_hit(reg_addr, `IRQ_REPORT_ADDR, reg_rd);

	// ======================================================================
	// Mask register

	logic [7:0] irq_source_mask_q;
	logic [7:0] irq_source_mask_d;
	logic [7:0] write_keep;

	always_comb
	begin
		write_keep = efr_write_enable ? 8'h00 : `MASK_HIGH_NIBBLE;
		irq_source_mask_d = irq_source_mask_q;
		if (mask_wr)
			irq_source_mask_d = (reg_wdata & ~write_keep)
				| (irq_source_mask_q & write_keep);
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			irq_source_mask_q <= `MASK_RESET;
		else
			irq_source_mask_q <= irq_source_mask_d;
	end

	logic en_rx_data;
	logic en_tx;
	logic en_line;
	logic en_modem;
	logic en_pause;
	logic en_rts;
	logic en_cts;

	assign en_rx_data = irq_source_mask_q[`MASK_RX_DATA_BIT];
	assign en_tx      = irq_source_mask_q[`MASK_TX_BIT];
	assign en_line    = irq_source_mask_q[`MASK_LINE_BIT];
	assign en_modem   = irq_source_mask_q[`MASK_MODEM_BIT];
	assign en_pause   = irq_source_mask_q[`MASK_PAUSE_BIT];
	assign en_rts     = irq_source_mask_q[`MASK_RTS_BIT];
	assign en_cts     = irq_source_mask_q[`MASK_CTS_BIT];

	assign sleep_mode = irq_source_mask_q[`MASK_SLEEP_BIT];

	// ======================================================================
	// Transmit-space event

	// The transmit source is an event, not a level: it fires when the
	// queue drops below its level or when the enable is set again, and
	// it is serviced by reading the report or loading new data.
	logic tx_below_q;
	logic tx_below_d;
	logic tx_en_q;
	logic tx_en_d;
	logic tx_set;
	logic tx_clr;
	logic tx_flag;

	always_comb
	begin
		tx_below_d = src.tx_below_level;
		tx_en_d    = en_tx;
		tx_set     = en_tx && src.tx_below_level
			&& (!tx_below_q || !tx_en_q);
		tx_clr     = thr_write || !src.tx_below_level;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			tx_below_q <= 1'b0;
			tx_en_q    <= 1'b0;
		end
		else
		begin
			tx_below_q <= tx_below_d;
			tx_en_q    <= tx_en_d;
		end
	end

	// ======================================================================
	// Sticky event flags

	uart_irq_pkg::irq_src_e source;

	logic tx_report_clr;
	logic pause_set;
	logic pause_flag;
	logic flow_clr;
	logic cts_flag;
	logic rts_flag;

	// Reading the report services the event that it showed.
	assign tx_report_clr = tx_clr
		|| (report_rd && source == uart_irq_pkg::SRC_TX);
	assign pause_set = en_pause && (src.pause_char_rx
		|| (efr_special_detect && src.special_char_match));
	assign flow_clr = report_rd
		&& source == uart_irq_pkg::SRC_FLOW;

	irq_event_latch u_tx_latch
	(
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.set     (tx_set),
		.clr     (tx_report_clr),
		.flag_q  (tx_flag)
	);

	irq_event_latch u_pause_latch
	(
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.set     (pause_set),
		.clr     (report_rd && source == uart_irq_pkg::SRC_PAUSE),
		.flag_q  (pause_flag)
	);

	irq_event_latch u_cts_latch
	(
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.set     (en_cts && src.cts_to_inactive),
		.clr     (flow_clr),
		.flag_q  (cts_flag)
	);

	irq_event_latch u_rts_latch
	(
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.set     (en_rts && src.rts_to_inactive),
		.clr     (flow_clr),
		.flag_q  (rts_flag)
	);

	// ======================================================================
	// Priority and report

	logic [7:0] irq_source_report;

	// Clearing a mask bit also hides an event flag already latched.
	irq_priority_encoder u_encoder
	(
		.line_error   (en_line && src.line_error),
		.rx_timeout   (en_rx_data && src.rx_timeout),
		.rx_data      (en_rx_data && src.rx_data_ready),
		.tx_space     (en_tx && tx_flag),
		.modem        (en_modem && src.modem_change),
		.pause_char   (en_pause && pause_flag),
		.flow_change  ((en_cts && cts_flag) || (en_rts && rts_flag)),
		.queue_enable (fcr_queue_enable),
		.source       (source),
		.report       (irq_source_report)
	);

	// ======================================================================
	// Read data and request pin

	logic [7:0] rdata_d;
	logic [7:0] rdata_q;
	logic       request_d;
	logic       request_q;

	always_comb
	begin
		rdata_d = rdata_q;
		if (mask_rd)
			rdata_d = irq_source_mask_q;
		else if (report_rd)
			rdata_d = irq_source_report;
		else if (reg_rd)
			rdata_d = `READ_UNMAPPED;
		request_d = (source != uart_irq_pkg::SRC_NONE);
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			rdata_q   <= 8'h00;
			request_q <= 1'b0;
		end
		else
		begin
			rdata_q   <= rdata_d;
			request_q <= request_d;
		end
	end

	assign reg_rdata          = rdata_q;
	assign service_request    = request_q;
	// The pin is left floating by the pad while its enable is low.
	assign service_request_oe = mcr_irq_output_enable;

endmodule : uart_interrupt_enable_identify

`default_nettype wire

// *** testbench/uart_irq_chk.sv ***
// Checker: port-level properties of the interrupt enable block.
// Assumes it is bound into that block, every port connected by name.
`timescale 1ns/10ps
`default_nettype none
`include "uart_irq_defines.svh"
module uart_irq_chk
(
	input wire logic                      clk_sys,
	input wire logic                      rst_n,
	input wire logic [2:0]                reg_addr,
	input wire logic                      reg_wr,
	input wire logic                      reg_rd,
	input wire logic [7:0]                reg_wdata,
	input wire logic [7:0]                reg_rdata,
	input wire logic                      efr_write_enable,
	input wire logic                      efr_special_detect,
	input wire logic                      fcr_queue_enable,
	input wire logic                      mcr_irq_output_enable,
	input wire uart_irq_pkg::irq_src_in_s src,
	input wire logic                      thr_write,
	input wire logic                      service_request,
	input wire logic                      service_request_oe,
	input wire logic                      sleep_mode
);
	logic [7:0] mask_d;
	logic [7:0] mask_q;
	// ==================
	// Shadow mask
	// The mask is no port, so a copy rebuilt from the writes stands in.
	always_comb
	begin
		mask_d = mask_q;
		if (reg_wr && reg_addr == `IRQ_MASK_ADDR)
			mask_d = efr_write_enable ? reg_wdata
				: {mask_q[7:4], reg_wdata[3:0]};
	end
	always_ff @(posedge clk_sys)
		mask_q <= rst_n ? mask_d : `MASK_RESET;
	// ==================
	// Properties
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence cts_evt_s;
		src.cts_to_inactive && mask_q[`MASK_CTS_BIT];
	endsequence
	sequence raised_s;
		##1 service_request;
	endsequence
	oe_follow_a: assert property (
		service_request_oe == mcr_irq_output_enable)
		else $error("pin enable differs from its control");
	sleep_set_a: assert property (
		reg_wr && reg_addr == `IRQ_MASK_ADDR && efr_write_enable
		|=> sleep_mode == $past(reg_wdata[`MASK_SLEEP_BIT]))
		else $error("sleep mode missed the written bit");
	mask_read_a: assert property (
		reg_rd && reg_addr == `IRQ_MASK_ADDR
		|=> reg_rdata == $past(mask_q))
		else $error("mask read back wrong");
	line_irq_a: assert property (
		src.line_error && mask_q[`MASK_LINE_BIT] |=> service_request)
		else $error("line error raised no request");
	cts_irq_a: assert property (cts_evt_s |=> raised_s)
		else $error("flow change raised no request");
	masked_quiet_a: assert property (
		mask_q == `MASK_RESET |=> !service_request)
		else $error("request with every source masked");
	mirror_bits_a: assert property (
		reg_rd && reg_addr == `IRQ_REPORT_ADDR
		|=> reg_rdata[7:6] == {2{$past(fcr_queue_enable)}})
		else $error("report top bits differ from queue enable");
	unmapped_read_a: assert property (
		reg_rd && reg_addr > `IRQ_REPORT_ADDR
		|=> reg_rdata == `READ_UNMAPPED)
		else $error("unmapped read returned data");
endmodule : uart_irq_chk
`default_nettype wire

// *** testbench/host_bus_model.sv ***
// Host side of the channel register bus: single byte accesses.
// Assumes the block answers a read at the edge that takes the strobe.
`timescale 1ns/10ps
`default_nettype none
module host_bus_model
(
	input  wire logic       clk_sys,
	input  wire logic [7:0] reg_rdata,
	output logic [2:0]      reg_addr,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic [7:0]      reg_wdata
);
	initial
	begin
		reg_addr = 3'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
	end
	// Released address and data lines show the inverse so a stale value cannot pass.
	task automatic xfer(input logic w, input logic [2:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge clk_sys);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = w;
		reg_rd = !w;
		@(posedge clk_sys);
		#1;
		q = reg_rdata;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask : xfer
endmodule : host_bus_model
`default_nettype wire

// *** testbench/tb_top.sv ***
// Bench top: clock, reset, host model, source stimulus, comparisons.
// Assumes the block, its checker and the host model compile first.
`timescale 1ns/10ps
`default_nettype none
`include "uart_irq_defines.svh"
module tb_top;
	logic                      clk_sys = 1'b0;
	logic                      rst_n = 1'b0;
	logic                      efr_write_enable = 1'b1;
	logic                      efr_special_detect = 1'b1;
	logic                      fcr_queue_enable = 1'b0;
	logic                      mcr_irq_output_enable = 1'b0;
	logic                      thr_write = 1'b0;
	uart_irq_pkg::irq_src_in_s src = '0;
	wire logic [2:0]           reg_addr;
	wire logic                 reg_wr;
	wire logic                 reg_rd;
	wire logic [7:0]           reg_wdata;
	wire logic [7:0]           reg_rdata;
	wire logic                 service_request;
	wire logic                 service_request_oe;
	wire logic                 sleep_mode;
	int                        err_count = 0;
	int                        check_count = 0;
	int                        cyc = 0;
	logic [31:0]               rnd = 32'h3;
	logic [7:0]                exp_mask = 8'h00;
	logic [7:0]                rv;
	logic [8:0]                tsrc [9] = '{9'h100, 9'h080, 9'h040,
		9'h020, 9'h010, 9'h008, 9'h004, 9'h002, 9'h001};
	logic [7:0]                tmask [9] = '{8'h04, 8'h01, 8'h01,
		8'h02, 8'h08, 8'h20, 8'h20, 8'h80, 8'h40};
	logic [7:0]                trpt [9] = '{8'h06, 8'h0C, 8'h04,
		8'h02, 8'h00, 8'h10, 8'h10, 8'h20, 8'h20};
	always #5 clk_sys = ~clk_sys;
	uart_interrupt_enable_identify u_dut (.clk_sys, .rst_n, .reg_addr,
		.reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .efr_write_enable,
		.efr_special_detect, .fcr_queue_enable, .mcr_irq_output_enable,
		.src, .thr_write, .service_request, .service_request_oe,
		.sleep_mode);
	host_bus_model u_host (.clk_sys, .reg_rdata, .reg_addr, .reg_wr,
		.reg_rd, .reg_wdata);
	// ==================
	// Helpers
	function automatic logic [7:0] rand8();
		rnd ^= rnd << 13;
		rnd ^= rnd >> 17;
		rnd ^= rnd << 5;
		return rnd[7:0];
	endfunction : rand8
	function automatic logic [7:0] next_mask(logic [7:0] o, logic [7:0] d);
		return efr_write_enable ? d : {o[7:4], d[3:0]};
	endfunction : next_mask
	function automatic logic [7:0] with_fcr(logic [7:0] c);
		return c | {fcr_queue_enable, fcr_queue_enable, 6'h00};
	endfunction : with_fcr
	task automatic step(int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : step
	task automatic check(logic [7:0] seen, logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic rd_rpt(logic [7:0] code);
		u_host.xfer(1'b0, `IRQ_REPORT_ADDR, 8'h00, rv);
		check(rv, with_fcr(code));
	endtask : rd_rpt
	task automatic set_mask(logic [7:0] d);
		u_host.xfer(1'b1, `IRQ_MASK_ADDR, d, rv);
		exp_mask = next_mask(exp_mask, d);
		u_host.xfer(1'b0, `IRQ_MASK_ADDR, 8'h00, rv);
		check(rv, exp_mask);
		check({7'h00, sleep_mode}, {7'h00, exp_mask[4]});
	endtask : set_mask
	task automatic finish_test();
		$display("errors %0d, checks %0d", err_count, check_count);
		if (err_count == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : finish_test
	// ==================
	// Scenarios
	initial
	begin
		step(16);
		rst_n = 1'b1;
		u_host.xfer(1'b0, `IRQ_MASK_ADDR, 8'h00, rv);
		check(rv, `MASK_RESET);
		rd_rpt(`RPT_IDLE);
		u_host.xfer(1'b1, `IRQ_REPORT_ADDR, 8'h3C, rv);
		rd_rpt(`RPT_IDLE);
		u_host.xfer(1'b0, 3'h5, 8'h00, rv);
		check(rv, `READ_UNMAPPED);
		efr_write_enable = 1'b0;
		set_mask(8'hFF);
		for (int i = 0; i < 12; i++)
		begin
			rv = rand8();
			efr_write_enable = rv[0];
			fcr_queue_enable = rv[1];
			mcr_irq_output_enable = rv[2];
			set_mask(rand8());
			rd_rpt(`RPT_IDLE);
		end
		efr_write_enable = 1'b1;
		// Each source: masked it stays silent, a pulse is lost.
		for (int i = 0; i < 9; i++)
		begin
			set_mask(~tmask[i]);
			src = tsrc[i];
			step(1);
			src = src & 9'h1F0;
			step(3);
			check({7'h00, service_request}, 8'h00);
			set_mask(tmask[i]);
			step(2);
			check({7'h00, service_request}, {7'h00, tsrc[i] > 9'h00F});
			src = tsrc[i];
			step(1);
			src = src & 9'h1F0;
			step(2);
			check({7'h00, service_request}, 8'h01);
			rd_rpt(trpt[i]);
			src = '0;
			step(2);
			rd_rpt(`RPT_IDLE);
		end
		set_mask(8'hFF);
		src = 9'h1F0;
		for (int i = 0; i < 5; i++)
		begin
			step(2);
			rd_rpt(trpt[i]);
			src = src & ~tsrc[i];
		end
		src = 9'h00A;
		step(1);
		src = '0;
		step(2);
		rd_rpt(8'h10);
		rd_rpt(8'h20);
		rd_rpt(`RPT_IDLE);
		// Loading new transmit data services the transmit-space event.
		src = 9'h020;
		step(3);
		check({7'h00, service_request}, 8'h01);
		thr_write = 1'b1;
		step(1);
		thr_write = 1'b0;
		step(2);
		check({7'h00, service_request}, 8'h00);
		src = '0;
		// A special character match is ignored while detection is off.
		efr_special_detect = 1'b0;
		src = 9'h004;
		step(1);
		src = '0;
		step(2);
		check({7'h00, service_request}, 8'h00);
		rd_rpt(`RPT_IDLE);
		finish_test();
	end
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			err_count++;
			finish_test();
		end
	end
endmodule : tb_top
bind uart_interrupt_enable_identify uart_irq_chk u_chk (.clk_sys, .rst_n,
	.reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .efr_write_enable,
	.efr_special_detect, .fcr_queue_enable, .mcr_irq_output_enable, .src,
	.thr_write, .service_request, .service_request_oe, .sleep_mode);
`default_nettype wire
